// >>> src/iep_regs.svh
// Register offsets, field layout and reset values of the interrupt enable/priority block
`ifndef IEP_REGS_SVH
`define IEP_REGS_SVH

// Register classes by address bits [7:4]; group index in bits [3:2]
`define IEP_BASE_EN      4'h0
`define IEP_BASE_PRIO    4'h1
`define IEP_BASE_FLAG    4'h2
`define IEP_BASE_CLR     4'h3

// Enable registers (also the interrupt enable of the flag registers)
`define IEP_OFF_EN_GRP2  8'h00
`define IEP_OFF_EN_GRP3  8'h04
`define IEP_OFF_EN_GRP4  8'h08
`define IEP_OFF_EN_PRIO  8'h0c
// Priority registers
`define IEP_OFF_PRIO0    8'h10
`define IEP_OFF_PRIO1    8'h14
`define IEP_OFF_PRIO2    8'h18
// Read-only sticky flags, write-one-to-clear companions
`define IEP_OFF_FLAG_GRP2 8'h20
`define IEP_OFF_FLAG_PRIO 8'h2c
`define IEP_OFF_CLR_GRP2  8'h30
`define IEP_OFF_CLR_PRIO  8'h3c

// Implemented bits per group
`define IEP_MASK_GRP2    16'h0007
`define IEP_MASK_GRP3    16'h39ff
`define IEP_MASK_GRP4    16'h00f6
`define IEP_MASK_PRIOSRC 16'h0fff
`define IEP_MASK_PRIO    16'h7777

`define IEP_RST_EN       16'h0000
`define IEP_RST_PRIO     16'h4444
`define IEP_PRIO_W       3
`define IEP_FIELD_STRIDE 4
`define IEP_NUM_PSRC     12

`endif

// >>> src/iep_pkg.sv
// Types shared by the interrupt enable/priority block
package iep_pkg;

    typedef logic [15:0] iep_word_t;

    typedef enum logic [2:0] {
        IEP_K_NONE = 3'h0,
        IEP_K_EN   = 3'h1,
        IEP_K_PRIO = 3'h3,
        IEP_K_FLAG = 3'h2,
        IEP_K_CLR  = 3'h6
    } iep_kind_e;

    typedef enum logic [1:0] {
        IEP_OKAY   = 2'h0,
        IEP_SLVERR = 2'h2
    } iep_resp_e;

    typedef struct packed {
        iep_kind_e  kind;
        logic [1:0] grp;
    } iep_dec_s;

    // One word per source group: prio = the twelve prioritised sources
    typedef struct packed {
        iep_word_t prio;
        iep_word_t g4;
        iep_word_t g3;
        iep_word_t g2;
    } iep_events_s;

    typedef struct packed {
        logic       valid;
        logic [2:0] level;
        logic [3:0] src;
    } iep_req_s;

endpackage : iep_pkg

// >>> src/iep_top.sv
// Interrupt enable, priority and sticky-flag registers with AXI4-Lite access
`timescale 1ns/10ps
`default_nettype none
`include "iep_regs.svh"

module iep_top
    import iep_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [31:0] s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    input  wire iep_events_s src_event,
    output iep_events_s      fwd_req,
    output iep_req_s         cpu_req,
    output logic             irq
);

    function automatic iep_dec_s iep_decode(input logic [31:0] a);
        iep_dec_s d;
        d.grp  = a[3:2];
        d.kind = IEP_K_NONE;
        if (a[31:8] == 24'h0 && a[1:0] == 2'h0) begin
            unique case (a[7:4])
                `IEP_BASE_EN:   d.kind = IEP_K_EN;
                `IEP_BASE_PRIO: d.kind = (a[3:2] == 2'h3) ? IEP_K_NONE : IEP_K_PRIO;
                `IEP_BASE_FLAG: d.kind = IEP_K_FLAG;
                `IEP_BASE_CLR:  d.kind = IEP_K_CLR;
                default:        d.kind = IEP_K_NONE;
            endcase
        end
        return d;
    endfunction : iep_decode

    function automatic iep_word_t iep_mask(input logic [1:0] g);
        iep_word_t m;
        unique case (g)
            2'h0:    m = `IEP_MASK_GRP2;
            2'h1:    m = `IEP_MASK_GRP3;
            2'h2:    m = `IEP_MASK_GRP4;
            default: m = `IEP_MASK_PRIOSRC;
        endcase
        return m;
    endfunction : iep_mask

    // Registers are 16 bits wide: only the two low byte lanes count
    function automatic iep_word_t iep_lanes(input logic [31:0] d, input logic [3:0] s);
        return d[15:0] & {{8{s[1]}}, {8{s[0]}}};
    endfunction : iep_lanes

    // Highest level wins; ties go to the lowest source index
    function automatic iep_req_s iep_pick(input logic [`IEP_NUM_PSRC-1:0] cand,
                                          input logic [3*`IEP_NUM_PSRC-1:0] lvl);
        iep_req_s r;
        r = '0;
        for (int i = 0; i < `IEP_NUM_PSRC; i++) begin
            if (cand[i] && (!r.valid || lvl[3*i +: 3] > r.level)) begin
                r.valid = 1'b1;
                r.level = lvl[3*i +: 3];
                r.src   = 4'(i);
            end
        end
        return r;
    endfunction : iep_pick

    iep_word_t en_q   [0:3];
    iep_word_t flag_q [0:3];
    iep_word_t prio_q [0:3];
    iep_word_t ev_w   [0:3];
    iep_word_t eff_en [0:3];
    logic [3:0] pend;

    // ---------------- Bus decode ----------------
    iep_dec_s  wr_dec;
    iep_dec_s  rd_dec;
    logic      wr_fire;
    logic      rd_fire;
    iep_word_t wr_bytes;
    iep_word_t rd_word;
    iep_word_t clr_bits;

    // Address and data taken together: no buffering of a lone channel
    assign wr_fire       = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready  = wr_fire;
    assign rd_fire       = s_axi_arvalid & ~s_axi_rvalid;
    assign s_axi_arready = rd_fire;
    assign wr_dec        = iep_decode(s_axi_awaddr);
    assign rd_dec        = iep_decode(s_axi_araddr);
    assign wr_bytes      = iep_lanes(s_axi_wdata, s_axi_wstrb);
    assign clr_bits      = (wr_fire && wr_dec.kind == IEP_K_CLR) ? wr_bytes : 16'h0;

    assign ev_w[0] = src_event.g2;
    assign ev_w[1] = src_event.g3;
    assign ev_w[2] = src_event.g4;
    assign ev_w[3] = src_event.prio;

    // ---------------- Register groups ----------------
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_grp
            logic      wr_en_hit;
            logic      clr_hit;
            iep_word_t mask;
            iep_word_t next_en;
            iep_word_t next_flag;
            assign mask      = iep_mask(2'(g));
            assign wr_en_hit = wr_fire && wr_dec.kind == IEP_K_EN && wr_dec.grp == 2'(g);
            assign clr_hit   = wr_dec.grp == 2'(g);
            assign next_en   = ((en_q[g] & ~{{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}})
                               | wr_bytes) & mask;
            // Event in the same cycle as its clear keeps the flag set
            assign next_flag = ((flag_q[g] & ~(clr_hit ? clr_bits : 16'h0))
                               | ev_w[g]) & mask;
            assign pend[g]   = |(flag_q[g] & eff_en[g]);

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    en_q[g]   <= `IEP_RST_EN;
                    flag_q[g] <= 16'h0;
                end else begin
                    if (wr_en_hit) begin
                        en_q[g] <= next_en;
                    end
                    flag_q[g] <= next_flag;
                end
            end
        end

        for (g = 0; g < 3; g++) begin : gen_prio
            logic      hit;
            iep_word_t next_prio;
            assign hit       = wr_fire && wr_dec.kind == IEP_K_PRIO && wr_dec.grp == 2'(g);
            assign next_prio = ((prio_q[g] & ~{{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}})
                               | wr_bytes) & `IEP_MASK_PRIO;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    prio_q[g] <= `IEP_RST_PRIO;
                end else if (hit) begin
                    prio_q[g] <= next_prio;
                end
            end
        end
    endgenerate
    // No fourth priority register: its slot decodes as unmapped
    assign prio_q[3] = 16'h0;

    // ---------------- Priority sources ----------------
    logic [`IEP_NUM_PSRC-1:0]   cand;
    logic [`IEP_NUM_PSRC-1:0]   lvl_nz;
    logic [3*`IEP_NUM_PSRC-1:0] lvl;
    iep_req_s                   best;

    genvar s;
    generate
        // Source s sits in priority register s/4, field s%4 from bit 0 up
        for (s = 0; s < `IEP_NUM_PSRC; s++) begin : gen_src
            assign lvl[3*s +: 3] = prio_q[s / 4][`IEP_FIELD_STRIDE*(s % 4) +: `IEP_PRIO_W];
            assign lvl_nz[s]     = |lvl[3*s +: 3];
            assign cand[s]       = flag_q[3][s] & en_q[3][s] & lvl_nz[s];
        end
    endgenerate

    assign eff_en[0] = en_q[0];
    assign eff_en[1] = en_q[1];
    assign eff_en[2] = en_q[2];
    assign eff_en[3] = en_q[3] & {4'h0, lvl_nz};
    assign best      = iep_pick(cand, lvl);
    assign irq       = |pend;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_req <= '0;
            fwd_req <= '0;
        end else begin
            cpu_req <= best;
            fwd_req <= '{prio: flag_q[3] & eff_en[3], g4: flag_q[2] & eff_en[2],
                         g3: flag_q[1] & eff_en[1], g2: flag_q[0] & eff_en[0]};
        end
    end

    // ---------------- Responses ----------------
    // A write lands at its request edge; the answer follows one cycle later
    assign rd_word = (rd_dec.kind == IEP_K_EN)   ? en_q[rd_dec.grp]   :
                     (rd_dec.kind == IEP_K_PRIO) ? prio_q[rd_dec.grp] :
                     (rd_dec.kind == IEP_K_FLAG) ? flag_q[rd_dec.grp] : 16'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= IEP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_dec.kind == IEP_K_NONE) ? IEP_SLVERR : IEP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= IEP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {16'h0, rd_word};
            s_axi_rresp  <= (rd_dec.kind == IEP_K_NONE) ? IEP_SLVERR : IEP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- Assertions ----------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_prio_reset_value: assert property ($rose(aresetn) |->
        prio_q[0] == 16'h4444 && prio_q[1] == 16'h4444 && prio_q[2] == 16'h4444)
        else $error("priority fields not at level four after reset");

    a_enable_reset_clear: assert property ($rose(aresetn) |->
        en_q[0] == 16'h0 && en_q[1] == 16'h0 && en_q[2] == 16'h0 && !irq)
        else $error("enable bits not cleared after reset");

    a_unimpl_bits_zero: assert property ((en_q[1] & 16'hc600) == 16'h0 &&
        (en_q[2] & 16'hff09) == 16'h0 && (prio_q[1] & 16'h8888) == 16'h0)
        else $error("unimplemented bit holds a one");

    a_gate_irq_cause: assert property (irq |->
        (|(flag_q[0] & en_q[0])) || (|(flag_q[1] & en_q[1])) ||
        (|(flag_q[2] & en_q[2])) || (|(flag_q[3] & eff_en[3])))
        else $error("interrupt raised without an enabled flag");

    a_flag_set_wins: assert property (src_event.g3[13] |=> flag_q[1][13])
        else $error("event lost against a clear");

    a_flag_sticky_hold: assert property (
        flag_q[2][7] && clr_bits[7] == 1'b0 |=> flag_q[2][7])
        else $error("flag dropped without a clear");

    a_clear_drops_flag: assert property (
        clr_bits[0] && wr_dec.grp == 2'h0 && !src_event.g2[0] |=> !flag_q[0][0])
        else $error("flag kept after its clear");

    // Arbiter inputs one cycle back, indexed by the winner that cpu_req now
    // carries; an indexed $past would take the index from the past as well
    logic [`IEP_NUM_PSRC-1:0]   cand_d;
    logic [3*`IEP_NUM_PSRC-1:0] lvl_d;

    always_ff @(posedge aclk) begin
        cand_d <= cand;
        lvl_d  <= lvl;
    end

    a_zero_prio_block: assert property (cpu_req.valid |->
        cpu_req.level != 3'h0 && cand_d[cpu_req.src])
        else $error("request forwarded for disabled source");

    a_level_from_field: assert property (cpu_req.valid |->
        cpu_req.level == lvl_d[3*cpu_req.src +: 3])
        else $error("forwarded level differs from field");

    a_prio_write_lands: assert property (
        wr_fire && wr_dec.kind == IEP_K_PRIO && wr_dec.grp == 2'h0 && s_axi_wstrb[1:0] == 2'h3
        |=> prio_q[0] == ($past(s_axi_wdata[15:0]) & `IEP_MASK_PRIO))
        else $error("priority write did not land");

    a_enable_write_lands: assert property (
        wr_fire && wr_dec.kind == IEP_K_EN && wr_dec.grp == 2'h0 && s_axi_wstrb[1:0] == 2'h3
        |=> en_q[0] == ($past(s_axi_wdata[15:0]) & `IEP_MASK_GRP2))
        else $error("enable write did not land");

    a_fwd_gated: assert property ($past(aresetn) |->
        fwd_req.g3 == $past(flag_q[1] & en_q[1]) &&
        fwd_req.g4 == $past(flag_q[2] & en_q[2]))
        else $error("forwarded bits differ from enabled flags");

    a_prio_no_irq: assert property (~|lvl_nz && ~|(flag_q[0] & en_q[0]) &&
        ~|(flag_q[1] & en_q[1]) && ~|(flag_q[2] & en_q[2]) |-> !irq)
        else $error("interrupt from a source at level zero");

    a_prio_seven_wins: assert property (cand[0] && lvl[2:0] == 3'h7 |=>
        cpu_req.valid && cpu_req.level == 3'h7)
        else $error("level seven source not forwarded");

    a_write_answer: assert property (wr_fire |=> s_axi_bvalid [*1] ##0 !s_axi_awready)
        else $error("write not answered next cycle");

    a_read_answer: assert property (rd_fire |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0)
        else $error("read not answered next cycle");

    generate
        for (s = 0; s < `IEP_NUM_PSRC; s++) begin : gen_arb_chk
            a_arb_highest: assert property ($past(cand[s]) && cpu_req.valid |->
                cpu_req.level >= $past(lvl[3*s +: 3]))
                else $error("lower level chosen over a higher one");
        end
    endgenerate

    c_write_taken:  cover property (wr_fire && wr_dec.kind == IEP_K_PRIO);
    c_irq_rise:     cover property ($rose(irq));
    c_level_seven:  cover property (cpu_req.valid && cpu_req.level == 3'h7);
    c_set_vs_clear: cover property (src_event.g2[0] && clr_bits[0] && wr_dec.grp == 2'h0);

endmodule : iep_top
`default_nettype wire

// >>> test/iep_core_model.sv
// Processor-side observer of prioritised interrupt requests
`timescale 1ns/10ps
`default_nettype none

module iep_core_model
    import iep_pkg::*;
(
    input  wire logic     aclk,
    input  wire logic     aresetn,
    input  wire iep_req_s req,
    input  wire logic     irq,
    output iep_req_s      seen
);
    // Takes a request only while irq is up, as a core would
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seen <= '0;
        end else if (irq && req.valid) begin
            seen <= req;
        end
    end
endmodule : iep_core_model

`default_nettype wire

// >>> test/tb.sv
// Self-checking bench of the interrupt enable and priority registers
`timescale 1ns/10ps
`default_nettype none

module tb
    import iep_pkg::*;
;
    logic        aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, irq;
    logic [31:0] awa, wd, ara, rd, rnd, d;
    logic [3:0]  ws;
    logic [1:0]  bresp, rresp, r;
    logic [15:0] w;
    logic [11:0] en, nz;
    logic [35:0] lv;
    iep_events_s ev, fwd;
    iep_req_s    creq, seen, ex;
    int          err_total, n_tests;
    logic [15:0] mk [7] = '{16'h0007, 16'h39ff, 16'h00f6, 16'h0fff,
                            16'h7777, 16'h7777, 16'h7777};

    iep_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .src_event(ev),
        .fwd_req(fwd), .cpu_req(creq), .irq(irq));

    iep_core_model i_core (.aclk(aclk), .aresetn(aresetn), .req(creq), .irq(irq), .seen(seen));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    // Highest level wins, ties to the lowest source index
    function automatic iep_req_s win(input logic [35:0] l, input logic [11:0] m);
        iep_req_s q;
        q = '0;
        for (int s = 0; s < 12; s++) begin
            if (m[s] && l[3*s+:3] > q.level) begin
                q.valid = 1'b1;
                q.level = l[3*s+:3];
                q.src   = 4'(s);
            end
        end
        return q;
    endfunction : win

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            err_total++;
        end
    endtask : chk

    task automatic tmo;
        $display("BAD handshake exp 1 got 0");
        err_total++;
        print_verdict();
    endtask : tmo

    task automatic axw(input logic [31:0] a, input logic [31:0] v, output logic [1:0] q);
        int n = 0;
        awa <= a;
        wd  <= v;
        awv <= 1'b1;
        wv  <= 1'b1;
        br  <= 1'b1;
        // Each channel is let go at its own handshake
        do begin
            @(posedge aclk);
            n++;
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
        end while (((awv && !awr) || (wv && !wr)) && n < 50);
        do begin
            @(posedge aclk);
            n++;
        end while (!bv && n < 50);
        q = bresp;
        br <= 1'b0;
        @(posedge aclk);
        if (n >= 50) tmo();
    endtask : axw

    task automatic axr(input logic [31:0] a, output logic [31:0] v, output logic [1:0] q);
        int n = 0;
        ara <= a;
        arv <= 1'b1;
        rr  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (!arr && n < 50);
        arv <= 1'b0;
        do begin
            @(posedge aclk);
            n++;
        end while (!rv && n < 50);
        v = rd;
        q = rresp;
        rr <= 1'b0;
        @(posedge aclk);
        if (n >= 50) tmo();
    endtask : axr

    task automatic wrb(input logic [31:0] a, input logic [31:0] v, input logic [31:0] e);
        axw(a, v, r);
        chk("bresp", 32'h0, {30'h0, r});
        axr(a, d, r);
        chk("rdata", e, d);
    endtask : wrb

    task automatic fire(input iep_events_s e);
        ev <= e;
        @(posedge aclk);
        ev <= '0;
        repeat (3) @(posedge aclk);
    endtask : fire

    task automatic rst_chk;
        for (int k = 0; k < 7; k++) begin
            axr(4 * k, d, r);
            chk("reset", (k < 4) ? 32'h0 : 32'h4444, d);
        end
    endtask : rst_chk

    initial begin
        {aresetn, awv, wv, br, arv, rr, awa, wd, ara} <= '0;
        ws <= 4'hf;
        ev <= '0;
        rnd = 32'h1bcb;
        err_total = 0;
        n_tests = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rst_chk();
        $display("test reset done");
        for (int k = 0; k < 7; k++) begin
            wrb(4 * k, 32'hffff_ffff, {16'h0, mk[k]});
        end
        axw(32'h1c, 32'hffff_ffff, r);
        chk("unmapped wr", 32'h2, {30'h0, r});
        axr(32'h1c, d, r);
        chk("unmapped rd", 32'h0, d);
        chk("unmapped rresp", 32'h2, {30'h0, r});
        $display("test layout done");
        // Round 0 all levels zero, round 1 all ties at seven
        for (int t = 0; t < 10; t++) begin
            for (int k = 0; k < 3; k++) begin
                rnd = lfsr(lfsr(rnd));
                w = (t == 0) ? 16'h0 : (t == 1) ? 16'hffff : rnd[15:0];
                wrb(32'h10 + 4 * k, {16'h0, w}, {16'h0, w & 16'h7777});
                for (int f = 0; f < 4; f++) begin
                    lv[3*(4*k+f)+:3] = w[4*f+:3];
                    nz[4*k+f]        = |w[4*f+:3];
                end
            end
            rnd = lfsr(rnd);
            en = (t < 2) ? 12'hfff : rnd[11:0];
            axw(32'h0c, {20'h0, en}, r);
            fire(iep_events_s'{prio: 16'h0fff, default: 16'h0});
            ex = win(lv, en);
            chk("cpu_req", {24'h0, ex}, {24'h0, creq});
            chk("irq", {31'h0, ex.valid}, {31'h0, irq});
            chk("fwd prio", {20'h0, en & nz}, {16'h0, fwd.prio});
            if (ex.valid) chk("core", {24'h0, ex}, {24'h0, seen});
            axr(32'h2c, d, r);
            chk("flags", 32'h0fff, d);
            axw(32'h3c, 32'h0fff, r);
            chk("irq clr", 32'h0, {31'h0, irq});
        end
        $display("test priority done");
        axw(32'h04, 32'h0, r);
        fire(iep_events_s'{g3: 16'hffff, default: 16'h0});
        chk("irq off", 32'h0, {31'h0, irq});
        chk("fwd off", 32'h0, {16'h0, fwd.g3});
        axr(32'h24, d, r);
        chk("flag g3", 32'h39ff, d);
        axw(32'h04, 32'h0800, r);
        repeat (2) @(posedge aclk);
        chk("irq on", 32'h1, {31'h0, irq});
        chk("fwd on", 32'h0800, {16'h0, fwd.g3});
        axw(32'h34, 32'hffff, r);
        chk("irq g3 clr", 32'h0, {31'h0, irq});
        $display("test enable done");
        // Event and its clear at the same edge: the event must win
        fork
            axw(32'h30, 32'h0001, r);
            begin
                ev <= iep_events_s'{g2: 16'h0001, g4: 16'hffff, default: 16'h0};
                @(posedge aclk);
                ev <= '0;
            end
        join
        axr(32'h20, d, r);
        chk("set wins", 32'h0001, d);
        axr(32'h28, d, r);
        chk("flag g4", 32'h00f6, d);
        chk("fwd g4", 32'h00f6, {16'h0, fwd.g4});
        chk("fwd g2", 32'h0001, {16'h0, fwd.g2});
        chk("irq g2 g4", 32'h1, {31'h0, irq});
        axw(32'h30, 32'hffff, r);
        axw(32'h38, 32'hffff, r);
        chk("irq g2 g4 clr", 32'h0, {31'h0, irq});
        $display("test set and clear done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rst_chk();
        ws <= 4'h1;
        wrb(32'h10, 32'h0000_1111, 32'h4411);
        ws <= 4'hf;
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule : tb

`default_nettype wire
